// *** design/bcdasm_pkg.sv ***
package bcdasm_pkg;

  // ==========================================================
  // datapath widths
  localparam int ACC_W    = 32;  // eight bcd digits in the accumulator
  localparam int OPD_W    = 16;  // four bcd digits in a short operand
  localparam int BIN_W    = 27;  // binary width able to hold 99999999
  localparam int DISC_AW  = 10;  // bit address width into the discrete image
  localparam int LEN_W    = 5;   // width of the bit range length
  localparam int DIV_CW   = 5;   // divider step counter width
  localparam int ADDR_W   = 8;   // register bus byte address width
  localparam int IRQ_W    = 5;   // interrupt status width
  localparam int FLAG_W   = 8;   // status flag vector width

  // ==========================================================
  // operand range limits and arithmetic constants
  localparam logic [LEN_W-1:0]  LEN_MIN   = 5'h01;       // shortest bit range
  localparam logic [LEN_W-1:0]  LEN_MAX   = 5'h10;       // longest bit range
  localparam logic [BIN_W:0]    TEN_POW8  = 28'h5f5e100; // 10^8, long wrap
  localparam logic [BIN_W:0]    TEN_POW4  = 28'h0002710; // 10^4, short wrap
  localparam logic [DIV_CW-1:0] DIV_LAST  = 5'h1a;       // last of 27 divide steps

  // ==========================================================
  // register byte offsets
  localparam logic [ADDR_W-1:0] REG_ACC   = 8'h00;  // accumulator, read only
  localparam logic [ADDR_W-1:0] REG_STK   = 8'h04;  // first stack level, read only
  localparam logic [ADDR_W-1:0] REG_FLAGS = 8'h08;  // live status flags, read only
  localparam logic [ADDR_W-1:0] REG_ISTAT = 8'h0c;  // sticky events, read clears
  localparam logic [ADDR_W-1:0] REG_IMASK = 8'h10;  // interrupt mask
  localparam logic [ADDR_W-1:0] REG_CTRL  = 8'h14;  // bit 0: accept commands

  // ==========================================================
  // reset values and field positions
  localparam logic [IRQ_W-1:0] IMASK_RST  = 5'h00;
  localparam logic             CTRL_RST   = 1'b1;
  localparam int CTRL_EN_BIT  = 0;
  localparam int IRQ_DONE     = 0;  // any operation completed
  localparam int IRQ_OVF      = 1;  // operand overflow
  localparam int IRQ_INV      = 2;  // non-bcd digit seen
  localparam int IRQ_LCARRY   = 3;  // long carry
  localparam int IRQ_LBORROW  = 4;  // long borrow

  // ==========================================================
  // commands from the sequencer
  typedef enum logic [2:0] {
    OP_NOP  = 3'h0,
    OP_LOAD = 3'h1,
    OP_ADD  = 3'h2,
    OP_SUB  = 3'h3,
    OP_MUL  = 3'h4,
    OP_DIVIDE_BY_BIT_RANGE = 3'h5
  } bcdasm_op_t;

  typedef struct packed {
    bcdasm_op_t         op;        // operation code
    logic [ACC_W-1:0]   load_data; // value for a load
    logic [DISC_AW-1:0] bit_addr;  // first bit of divide operand
    logic [LEN_W-1:0]   bit_len;   // bits in divide operand
  } bcdasm_cmd_t;

  // status flags, msb first as read at REG_FLAGS
  typedef struct packed {
    logic operand_overflow_flag;
    logic zero_result_flag;
    logic negative_flag;
    logic invalid_bcd_flag;
    logic short_borrow_flag;
    logic long_borrow_flag;
    logic short_carry_flag;
    logic long_carry_flag;
  } bcdasm_flags_t;

  typedef enum {ST_IDLE, ST_DIV} bcdasm_fsm_t;

endpackage

// *** design/bcdasm_core.sv ***
// Decided for this implementation: the strobed register port and the address map.
`timescale 1ns/10ps

module bcdasm_core #(
  parameter int STK_DEPTH = 8,     // accumulator stack levels
  parameter int DISC_W    = 1024   // bits in the discrete image
) (
  // clock and reset
  input  wire logic                           ref_clk,
  input  wire logic                           sys_rst,
  // sequencer command port
  input  wire logic                           cmd_valid,
  input  wire bcdasm_pkg::bcdasm_cmd_t        cmd,
  input  wire logic [DISC_W-1:0]              disc_bits,
  output logic                                busy,
  output logic                                op_done,
  // results
  output logic [bcdasm_pkg::ACC_W-1:0]        acc_value,
  output logic [bcdasm_pkg::ACC_W-1:0]        stack_top,
  output bcdasm_pkg::bcdasm_flags_t           flags,
  // register bus
  input  wire logic [bcdasm_pkg::ADDR_W-1:0]  reg_addr,
  input  wire logic [31:0]                    reg_wdata,
  input  wire logic                           reg_wr,
  input  wire logic                           reg_rd,
  output logic [31:0]                         reg_rdata,
  // interrupt
  output logic                                irq
);
  import bcdasm_pkg::*;

  // ==========================================================
  // elaboration checks
  // push and pop need two levels
  if (STK_DEPTH < 2) begin : g_chk_depth
    $error("stack needs at least two levels");
  end

  if (DISC_W < OPD_W || DISC_W > (1 << DISC_AW)) begin : g_chk_disc
    $error("discrete image width out of range");
  end

  // ==========================================================
  // state record
  typedef struct packed {
    bcdasm_fsm_t                    fsm;      // idle or dividing
    logic [ACC_W-1:0]               acc;      // bcd accumulator
    logic [STK_DEPTH-1:0][ACC_W-1:0] stk;     // level 0 is the top
    bcdasm_flags_t                  flg;      // status flags
    logic                           done;     // completion pulse
    logic [BIN_W-1:0]               quo;      // dividend shifting into quotient
    logic [OPD_W:0]                 rem;      // partial remainder
    logic [OPD_W-1:0]               dvs;      // binary divisor
    logic [DIV_CW-1:0]              cnt;      // divide step
    logic                           dv_inv;   // accumulator was non-bcd
    logic [IRQ_W-1:0]               istat;    // sticky events
    logic [IRQ_W-1:0]               imask;    // event mask
    logic                           cmd_en;   // command acceptance
    logic [31:0]                    rdata;    // read answer
    logic                           irq;      // interrupt level
    logic                           bsy;      // divide running
  } bcdasm_state_t;

  bcdasm_state_t st_r;   // registered state
  bcdasm_state_t st_nxt; // next state

  // ==========================================================
  // bcd helpers
  // bcd to binary, digit by digit from the top
  function automatic logic [BIN_W-1:0] bcd2bin(input logic [ACC_W-1:0] v);
    logic [BIN_W-1:0] r;
    r = '0;
    for (int i = ACC_W/4 - 1; i >= 0; i--) begin
      r = BIN_W'(r * BIN_W'(10) + BIN_W'(v[i*4 +: 4]));
    end
    return r;
  endfunction

  // binary to bcd by shift and add three
  function automatic logic [ACC_W-1:0] bin2bcd(input logic [BIN_W-1:0] v);
    logic [ACC_W-1:0] b;
    b = '0;
    for (int i = BIN_W - 1; i >= 0; i--) begin
      for (int d = 0; d < ACC_W/4; d++) begin
        if (b[d*4 +: 4] >= 4'h5) begin
          b[d*4 +: 4] = 4'(b[d*4 +: 4] + 4'h3);
        end
      end
      b = {b[ACC_W-2:0], v[i]};
    end
    return b;
  endfunction

  // every nibble a decimal digit
  function automatic logic all_bcd(input logic [ACC_W-1:0] v);
    logic ok;
    ok = 1'b1;
    for (int d = 0; d < ACC_W/4; d++) begin
      if (v[d*4 +: 4] > 4'h9) begin
        ok = 1'b0;
      end
    end
    return ok;
  endfunction

  // ==========================================================
  // operand preparation
  logic [ACC_W-1:0]  top;       // first stack level
  logic [BIN_W-1:0]  a_bin;     // accumulator in binary
  logic [BIN_W-1:0]  b_bin;     // stack top in binary
  logic [BIN_W-1:0]  a_lo;      // low four digits of accumulator
  logic [BIN_W-1:0]  b_lo;      // low four digits of stack top
  logic              ab_ok;     // both operands decimal
  logic [BIN_W:0]    sum;       // binary sum
  logic [BIN_W:0]    dif;       // wrapped difference
  logic [BIN_W:0]    prod;      // four by four digit product
  logic [DISC_W-1:0] shifted;   // image moved down to the range start
  logic [OPD_W-1:0]  fmt_opd;   // masked bit range operand
  logic              len_ok;    // bit range length legal
  logic              accept;    // command taken this cycle

  assign top = st_r.stk[0];

  always_comb begin
    a_bin   = bcd2bin(st_r.acc);
    b_bin   = bcd2bin(top);
    a_lo    = bcd2bin({16'h0000, st_r.acc[OPD_W-1:0]});
    b_lo    = bcd2bin({16'h0000, top[OPD_W-1:0]});
    ab_ok   = all_bcd(st_r.acc) && all_bcd(top);
    sum     = {1'b0, a_bin} + {1'b0, b_bin};

    // ten's complement wrap when the stack value is larger
    if (a_bin < b_bin) begin
      dif = TEN_POW8 + {1'b0, a_bin} - {1'b0, b_bin};
    end else begin
      dif = {1'b0, a_bin} - {1'b0, b_bin};
    end

    // never above eight digits
    prod    = (BIN_W+1)'(a_lo * b_lo);

    // window starts at bit_addr
    shifted = disc_bits >> cmd.bit_addr;
    len_ok  = (cmd.bit_len >= LEN_MIN) && (cmd.bit_len <= LEN_MAX);
    // a range shorter than sixteen bits keeps only its own bits
    fmt_opd = shifted[OPD_W-1:0] & OPD_W'((32'h1 << cmd.bit_len) - 32'h1);

    // refused commands leave no trace
    accept  = cmd_valid && st_r.cmd_en && (st_r.fsm == ST_IDLE);
  end

  // ==========================================================
  // divider step, one quotient bit per cycle
  // restoring: subtract when it fits
  logic [OPD_W:0]   rem_sh;   // remainder with next dividend bit
  logic             q_bit;    // quotient bit of this step
  logic [OPD_W:0]   rem_new;  // remainder after the step
  logic [BIN_W-1:0] quo_new;  // quotient after the step

  always_comb begin
    rem_sh  = {st_r.rem[OPD_W-1:0], st_r.quo[BIN_W-1]};
    q_bit   = (rem_sh >= {1'b0, st_r.dvs});
    rem_new = q_bit ? (rem_sh - {1'b0, st_r.dvs}) : rem_sh;
    quo_new = {st_r.quo[BIN_W-2:0], q_bit};
  end

  // ==========================================================
  // next state
  logic [IRQ_W-1:0] ev;      // events raised this cycle
  logic [ACC_W-1:0] res_bcd; // committed accumulator value

  always_comb begin
    st_nxt       = st_r;
    st_nxt.done  = 1'b0;
    ev           = '0;
    res_bcd      = st_r.acc;

    // ---- command execution
    if (accept) begin
      case (cmd.op)
        OP_LOAD: begin
          // old accumulator goes down one level
          for (int i = STK_DEPTH - 1; i > 0; i--) begin
            st_nxt.stk[i] = st_r.stk[i-1];
          end
          st_nxt.stk[0] = st_r.acc;
          st_nxt.acc    = cmd.load_data;
          st_nxt.done   = 1'b1;
        end
        OP_ADD, OP_SUB, OP_MUL: begin
          if (!ab_ok) begin
            // non-decimal digits: data left as is, flags report it
            res_bcd                       = st_r.acc;
            st_nxt.flg.invalid_bcd_flag   = 1'b1;
            st_nxt.flg.negative_flag      = 1'b0;
            ev[IRQ_INV]                   = 1'b1;
          end else begin
            st_nxt.flg.invalid_bcd_flag   = 1'b0;
            st_nxt.flg.negative_flag      = 1'b0;
            if (cmd.op == OP_ADD) begin
              // wrap at eight digits, the lost digit is the long carry
              if (sum >= TEN_POW8) begin
                res_bcd = bin2bcd(BIN_W'(sum - TEN_POW8));
              end else begin
                res_bcd = bin2bcd(BIN_W'(sum));
              end
            end else if (cmd.op == OP_SUB) begin
              res_bcd                  = bin2bcd(BIN_W'(dif));
              st_nxt.flg.negative_flag = (a_bin < b_bin);
            end else begin
              res_bcd = bin2bcd(BIN_W'(prod));
            end
            // the popped stack moves up, bottom fills with zero
            for (int i = 0; i < STK_DEPTH - 1; i++) begin
              st_nxt.stk[i] = st_r.stk[i+1];
            end
            st_nxt.stk[STK_DEPTH-1] = '0;
          end
          // carry flags belong to add, borrow flags to subtract
          if (cmd.op == OP_ADD) begin
            st_nxt.flg.short_carry_flag = ab_ok && ((a_lo + b_lo) >= BIN_W'(TEN_POW4));
            st_nxt.flg.long_carry_flag  = ab_ok && (sum >= TEN_POW8);
            ev[IRQ_LCARRY]              = ab_ok && (sum >= TEN_POW8);
          end
          if (cmd.op == OP_SUB) begin
            st_nxt.flg.short_borrow_flag = ab_ok && (a_lo < b_lo);
            st_nxt.flg.long_borrow_flag  = ab_ok && (a_bin < b_bin);
            ev[IRQ_LBORROW]              = ab_ok && (a_bin < b_bin);
          end

          st_nxt.acc                  = res_bcd;
          st_nxt.flg.zero_result_flag = (res_bcd == '0);
          st_nxt.done                 = 1'b1;
        end
        OP_DIVIDE_BY_BIT_RANGE: begin
          // an empty or too long range, or a zero divisor, is unusable
          if (!len_ok || fmt_opd == '0 || !all_bcd({16'h0000, fmt_opd})) begin
            st_nxt.flg.operand_overflow_flag = !len_ok || (fmt_opd == '0);
            st_nxt.flg.invalid_bcd_flag      = len_ok && (fmt_opd != '0);
            st_nxt.flg.negative_flag         = 1'b0;
            st_nxt.flg.zero_result_flag      = (st_r.acc == '0);
            ev[IRQ_OVF]                      = !len_ok || (fmt_opd == '0);
            ev[IRQ_INV]                      = len_ok && (fmt_opd != '0);
            st_nxt.done                      = 1'b1;
          end else begin
            // start the serial divide on binary values
            st_nxt.fsm    = ST_DIV;
            st_nxt.quo    = a_bin;
            st_nxt.rem    = '0;
            st_nxt.dvs    = OPD_W'(bcd2bin({16'h0000, fmt_opd}));
            st_nxt.cnt    = '0;
            st_nxt.dv_inv = !all_bcd(st_r.acc);
          end
        end
        default: begin
          // nop and unknown codes change nothing
        end
      endcase
      ev[IRQ_DONE] = st_nxt.done;
    end

    // ---- divide in progress, commands held off by busy
    case (st_r.fsm)
      ST_IDLE: begin
        // nothing running
      end
      ST_DIV: begin
        st_nxt.quo = quo_new;
        st_nxt.rem = rem_new;
        st_nxt.cnt = DIV_CW'(st_r.cnt + 1'b1);

        if (st_r.cnt == DIV_LAST) begin
          // quotient, remainder and flags land in one cycle
          st_nxt.fsm    = ST_IDLE;
          st_nxt.acc    = bin2bcd(quo_new);
          st_nxt.stk[0] = bin2bcd(BIN_W'(rem_new));
          st_nxt.flg.operand_overflow_flag = 1'b0;
          st_nxt.flg.invalid_bcd_flag      = st_r.dv_inv;
          st_nxt.flg.negative_flag         = 1'b0;
          st_nxt.flg.zero_result_flag      = (quo_new == '0);
          st_nxt.done                      = 1'b1;
          ev[IRQ_DONE]                     = 1'b1;
          ev[IRQ_INV]                      = st_r.dv_inv;
        end
      end
      default: begin
        st_nxt.fsm = ST_IDLE;
      end
    endcase

    // ---- register bus writes
    if (reg_wr) begin
      case (reg_addr)
        REG_IMASK: st_nxt.imask  = reg_wdata[IRQ_W-1:0];
        REG_CTRL:  st_nxt.cmd_en = reg_wdata[CTRL_EN_BIT];
        default: begin
          // read-only and unmapped addresses ignore writes
        end
      endcase
    end

    // ---- register bus reads, answered next cycle
    st_nxt.rdata = '0;
    if (reg_rd) begin
      case (reg_addr)
        REG_ACC:   st_nxt.rdata = st_r.acc;
        REG_STK:   st_nxt.rdata = top;
        REG_FLAGS: st_nxt.rdata = {24'h000000, st_r.flg};
        REG_ISTAT: st_nxt.rdata = {27'h0, st_r.istat};
        REG_IMASK: st_nxt.rdata = {27'h0, st_r.imask};
        REG_CTRL:  st_nxt.rdata = {31'h0, st_r.cmd_en};
        default:   st_nxt.rdata = '0;
      endcase
    end

    // ---- sticky events, a new event beats the read clear
    if (reg_rd && reg_addr == REG_ISTAT) begin
      st_nxt.istat = ev;
    end else begin
      st_nxt.istat = st_r.istat | ev;
    end

    st_nxt.irq = |(st_nxt.istat & st_nxt.imask);

    // busy kept in its own flop
    st_nxt.bsy = (st_nxt.fsm == ST_DIV);
  end

  // ==========================================================
  // state register
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      // enable comes up set
      st_r        <= '0;
      st_r.fsm    <= ST_IDLE;
      st_r.imask  <= IMASK_RST;
      st_r.cmd_en <= CTRL_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ==========================================================
  // outputs, all straight from the state register
  assign busy      = st_r.bsy;
  assign op_done   = st_r.done;
  assign acc_value = st_r.acc;
  assign stack_top = st_r.stk[0];
  assign flags     = st_r.flg;
  assign reg_rdata = st_r.rdata;
  assign irq       = st_r.irq;

endmodule // bcdasm_core

// *** verification/bcdasm_monitor.sv ***
`timescale 1ns/10ps

// ==========================================================
// port checker for the bcd accumulator core
module bcdasm_monitor #(
  parameter int DISC_W = 1024  // bits in the discrete image
) (
  // clock and reset
  input wire logic                          ref_clk,
  input wire logic                          sys_rst,
  // command side
  input wire logic                          cmd_valid,
  input wire bcdasm_pkg::bcdasm_cmd_t       cmd,
  input wire logic [DISC_W-1:0]             disc_bits,
  input wire logic                          busy,
  input wire logic                          op_done,
  // results
  input wire logic [bcdasm_pkg::ACC_W-1:0]  acc_value,
  input wire logic [bcdasm_pkg::ACC_W-1:0]  stack_top,
  input wire bcdasm_pkg::bcdasm_flags_t     flags,
  // register writes, only to follow the enable bit
  input wire logic [bcdasm_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [31:0]                   reg_wdata,
  input wire logic                          reg_wr
);
  import bcdasm_pkg::*;

  logic              en_r;    // shadow of the accept enable
  bcdasm_op_t        last_r;  // last accepted operation
  logic              take;    // command accepted this edge
  logic              len_bad; // divide length outside range
  logic [DISC_W-1:0] sh;      // image shifted to the operand
  logic [15:0]       opd;     // masked divide operand

  assign take    = cmd_valid && !busy && en_r;
  assign len_bad = (cmd.bit_len < LEN_MIN) || (cmd.bit_len > LEN_MAX);
  assign sh      = disc_bits >> cmd.bit_addr;
  assign opd     = sh[15:0] & 16'((17'h1 << cmd.bit_len) - 17'h1);

  // shadow state; the enable must be tracked or refused commands look lost
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      en_r   <= CTRL_RST;
      last_r <= OP_NOP;
    end else begin
      if (reg_wr && reg_addr == REG_CTRL) en_r <= reg_wdata[CTRL_EN_BIT];
      if (take) last_r <= cmd.op;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  // ==========================================================
  // sequences
  sequence s_commit;
    op_done && !busy;
  endsequence
  sequence s_div_run;
    (busy && !op_done)[*8] ##19 busy ##1 (!busy && op_done);
  endsequence

  // ==========================================================
  // properties
  property p_single_done;
    take && (cmd.op inside {OP_LOAD, OP_ADD, OP_SUB, OP_MUL}) |=> s_commit;
  endproperty
  a_single_done: assert property (p_single_done) else $error("single op done missing");

  property p_load_push;
    take && cmd.op == OP_LOAD |=>
      acc_value == $past(cmd.load_data) && stack_top == $past(acc_value);
  endproperty
  a_load_push: assert property (p_load_push) else $error("load push wrong");

  property p_div_run;
    $rose(busy) |-> s_div_run;
  endproperty
  a_div_run: assert property (p_div_run) else $error("divide run length wrong");

  property p_div_refused;
    take && cmd.op == OP_DIVIDE_BY_BIT_RANGE && (len_bad || opd == 16'h0000) |=>
      s_commit and (flags.operand_overflow_flag && $stable(acc_value));
  endproperty
  a_div_refused: assert property (p_div_refused) else $error("bad divide not refused");

  property p_zero;
    op_done && (last_r inside {OP_ADD, OP_SUB, OP_MUL}) |->
      flags.zero_result_flag == (acc_value == 32'h0);
  endproperty
  a_zero: assert property (p_zero) else $error("zero flag wrong");

  property p_sub_negative;
    op_done && last_r == OP_SUB && !flags.invalid_bcd_flag |->
      flags.negative_flag == ($past(stack_top) > $past(acc_value));
  endproperty
  a_sub_negative: assert property (p_sub_negative) else $error("negative flag wrong");

  property p_borrow_hold;
    op_done && last_r == OP_ADD |->
      $stable(flags.short_borrow_flag) && $stable(flags.long_borrow_flag);
  endproperty
  a_borrow_hold: assert property (p_borrow_hold) else $error("add touched borrows");

  property p_carry_hold;
    op_done && last_r == OP_SUB |->
      $stable(flags.short_carry_flag) && $stable(flags.long_carry_flag);
  endproperty
  a_carry_hold: assert property (p_carry_hold) else $error("sub touched carries");

  property p_done_cause;
    op_done |-> $past(take) || $fell(busy);
  endproperty
  a_done_cause: assert property (p_done_cause) else $error("done without cause");

endmodule // bcdasm_monitor

bind bcdasm_core bcdasm_monitor #(.DISC_W(DISC_W)) bcdasm_monitor_inst (
  .ref_clk(ref_clk), .sys_rst(sys_rst), .cmd_valid(cmd_valid), .cmd(cmd),
  .disc_bits(disc_bits), .busy(busy), .op_done(op_done), .acc_value(acc_value),
  .stack_top(stack_top), .flags(flags), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr)
);

// *** verification/bcdasm_seq_model.sv ***
`timescale 1ns/10ps

// ==========================================================
// sequencer model: offers commands and collects the answer
module bcdasm_seq_model (
  // clock and answers
  input wire logic                      ref_clk,
  input wire logic                      op_done,
  input wire bcdasm_pkg::bcdasm_flags_t flags,
  // command out
  output logic                          cmd_valid,
  output bcdasm_pkg::bcdasm_cmd_t       cmd
);
  import bcdasm_pkg::*;

  initial begin
    cmd_valid = 1'b0;
    cmd       = '0;
  end

  // hold keeps the offer up that many cycles, to poke a busy core
  task automatic issue(input bcdasm_cmd_t c, input int hold, input bit bad,
                       output int lat, output bcdasm_flags_t f);
    int n;
    if (!bad && c.op == OP_DIVIDE_BY_BIT_RANGE && (c.bit_len < LEN_MIN || c.bit_len > LEN_MAX))
      c.bit_len = LEN_MIN;
    lat = 0;
    f   = '0;
    n   = 1;
    @(posedge ref_clk);
    cmd       <= c;
    cmd_valid <= 1'b1;
    @(posedge ref_clk);
    while (n < 40 && lat == 0) begin
      // released fields flip so stale values never pass
      if (n >= hold) begin
        cmd_valid <= 1'b0;
        cmd       <= bcdasm_cmd_t'(~c);
      end
      #1;
      if (op_done === 1'b1) begin
        lat = n;
        f   = flags;
      end else begin
        @(posedge ref_clk);
        n++;
      end
    end
  endtask
endmodule // bcdasm_seq_model

// *** verification/testbench.sv ***
`timescale 1ns/10ps

// ==========================================================
// self checking bench for the bcd accumulator core
module testbench;
  import bcdasm_pkg::*;

  logic            ref_clk, sys_rst, busy, op_done, irq, cmd_valid, reg_wr, reg_rd;
  bcdasm_cmd_t     cmd;
  logic [1023:0]   disc_bits;
  logic [31:0]     acc_value, stack_top, reg_wdata, reg_rdata, rd;
  bcdasm_flags_t   flags, fl;
  logic [7:0]      reg_addr;
  int              fail_count, tests_run, lat, cyc;

  bcdasm_core bcdasm_core_inst (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .cmd_valid(cmd_valid), .cmd(cmd), .disc_bits(disc_bits), .busy(busy),
    .op_done(op_done), .acc_value(acc_value), .stack_top(stack_top),
    .flags(flags), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq));
  bcdasm_seq_model bcdasm_seq_model_inst (.ref_clk(ref_clk), .op_done(op_done),
    .flags(flags), .cmd_valid(cmd_valid), .cmd(cmd));

  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  // hang guard, far above the couple of hundred cycles of the run
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      final_report();
    end
  end

  task automatic final_report();
    if (fail_count == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task automatic check(input string n, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      $display("ERROR %s expected %h seen %h", n, e, g);
      fail_count++;
    end
  endtask

  // ==========================================================
  // bus and command helpers
  task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0; reg_wdata <= ~d;
  endtask

  task automatic reg_read(input logic [7:0] a);
    @(posedge ref_clk);
    reg_rd <= 1'b1; reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 rd = reg_rdata;
  endtask

  task automatic go(input bcdasm_op_t o, input logic [31:0] d = '0,
                    input logic [9:0] a = '0, input logic [4:0] l = 5'h01,
                    input int hold = 1, input bit bad = 0);
    bcdasm_cmd_t c;
    c = '{op: o, load_data: d, bit_addr: a, bit_len: l};
    bcdasm_seq_model_inst.issue(c, hold, bad, lat, fl);
  endtask

  task automatic do_reset();
    @(posedge ref_clk) sys_rst <= 1'b1;
    @(posedge ref_clk);
    @(posedge ref_clk) sys_rst <= 1'b0;
  endtask

  // ==========================================================
  // scenarios
  task automatic t_regs();
    check("acc rst", 32'h0, acc_value);
    check("flags rst", 32'h0, 32'(flags));
    reg_read(REG_CTRL); check("ctrl rst", 32'h1, rd);
    reg_read(REG_IMASK); check("imask rst", 32'h0, rd);
    reg_write(REG_IMASK, 32'h1f); reg_read(REG_IMASK); check("imask rw", 32'h1f, rd);
    reg_write(REG_ACC, 32'h55); reg_read(REG_ACC); check("acc ro", 32'h0, rd);
    reg_read(8'h40); check("unmapped", 32'h0, rd);
    reg_write(REG_CTRL, 32'h0);
    go(OP_LOAD, 32'h5); check("off lat", 32'h0, 32'(lat));
    check("off acc", 32'h0, acc_value);
    reg_write(REG_CTRL, 32'h1);
  endtask

  task automatic t_add();
    do_reset();
    go(OP_LOAD, 32'h99999999);
    go(OP_LOAD, 32'h00000001);
    check("push", 32'h99999999, stack_top);
    reg_write(REG_IMASK, 32'h08);
    repeat (2) @(posedge ref_clk);
    #1 check("irq masked", 32'h0, 32'(irq));
    go(OP_ADD); check("add lat", 32'h1, 32'(lat));
    check("add acc", 32'h0, acc_value);
    check("add pop", 32'h0, stack_top);
    check("add flags", 32'h43, 32'(fl));
    reg_read(REG_FLAGS); check("flags reg", 32'h43, rd);
    check("irq set", 32'h1, 32'(irq));
    reg_read(REG_ISTAT); check("istat", 32'h09, rd);
    reg_read(REG_ISTAT); check("istat clr", 32'h0, rd);
    check("irq clr", 32'h0, 32'(irq));
  endtask

  task automatic t_sub_mul();
    do_reset();
    go(OP_LOAD, 32'h7);
    go(OP_LOAD, 32'h5);
    go(OP_SUB); check("sub acc", 32'h99999998, acc_value);
    check("sub flags", 32'h2c, 32'(fl));
    go(OP_LOAD, 32'h1234);
    go(OP_LOAD, 32'h5);
    go(OP_MUL); check("mul acc", 32'h6170, acc_value);
    check("mul pop", 32'h99999998, stack_top);
    check("mul flags", 32'h0c, 32'(fl));
  endtask

  task automatic t_invalid();
    do_reset();
    go(OP_LOAD, 32'h0000000a);
    go(OP_LOAD, 32'h1);
    go(OP_ADD); check("inv acc", 32'h1, acc_value);
    check("inv stack", 32'h0000000a, stack_top);
    check("inv flags", 32'h10, 32'(fl));
  endtask

  task automatic t_divide();
    logic [9:0] a [3];
    logic [4:0] l [3];
    a = '{10'd16, 10'd16, 10'd100};
    l = '{5'd0, 5'd17, 5'd4};
    do_reset();
    go(OP_LOAD, 32'h100);
    go(OP_DIVIDE_BY_BIT_RANGE, 32'h0, 10'd16, 5'd8, 5); check("div lat", 32'd28, 32'(lat));
    check("quot", 32'h14, acc_value);
    check("rem", 32'h2, stack_top);
    check("div flags", 32'h0, 32'(fl));
    for (int i = 0; i < 3; i++) begin
      go(OP_DIVIDE_BY_BIT_RANGE, 32'h0, a[i], l[i], 1, 1); check("ovf lat", 32'h1, 32'(lat));
      check("ovf flag", 32'h1, 32'(fl.operand_overflow_flag));
      check("ovf acc", 32'h14, acc_value);
    end
    go(OP_DIVIDE_BY_BIT_RANGE, 32'h0, 10'd14, 5'd4, 1, 1); check("bad digit", 32'h10, 32'(fl));
    reg_read(REG_ISTAT); check("div istat", 32'h07, rd);
  endtask

  initial begin
    sys_rst = 1'b1; reg_wr = 1'b0; reg_rd = 1'b0; reg_addr = '0; reg_wdata = '0;
    disc_bits = '0; disc_bits[23:16] = 8'h07;
    fail_count = 0; tests_run = 0; cyc = 0;
    repeat (16) @(posedge ref_clk);
    sys_rst <= 1'b0;
    t_regs();
    t_add();
    t_sub_mul();
    t_invalid();
    t_divide();
    final_report();
  end
endmodule // testbench
